//--- hdl/bsc_defines.svh
// Purpose: constants of the middle boundary scan segment (cells 16 to 56)
// Assumes: one clock, hclk; tap strobes arrive synchronous to it
// Notes: positions are absolute chain positions
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

`define BSC_SEG_FIRST 16
`define BSC_SEG_LEN 41
`define BSC_CHAIN_LEN 98
`define BSC_NUM_CHAN 4
`define BSC_NUM_IO 8

// instruction codes
`define BSC_IR_EXTEST 3'h0
`define BSC_IR_SAMPLE 3'h4

// fixed cell positions
`define BSC_POS_IO_DIR 16
`define BSC_POS_MODE1 33
`define BSC_POS_INT 50
`define BSC_POS_ACK 51
`define BSC_POS_ACK_CTL 52
`define BSC_POS_WR 53
`define BSC_POS_RD 54
`define BSC_POS_ALE 55
`define BSC_POS_CS 56

// per-channel groups of eight cells
`define BSC_CH0_BASE 25
`define BSC_CH1_BASE 17
`define BSC_CH2_BASE 42
`define BSC_CH3_BASE 34
`define BSC_OFS_TCLK 0
`define BSC_OFS_TDP 1
`define BSC_OFS_TDN 2
`define BSC_OFS_RCLK 3
`define BSC_OFS_RXP 4
`define BSC_OFS_RXN 5
`define BSC_OFS_CTL 6
`define BSC_OFS_LOS 7
`define BSC_GROUP_LAST 7
// middle of the groups of channels 2 and 3, counted from the loss of signal cell
`define BSC_ROFS_RXN 1
`define BSC_ROFS_RXP 2
`define BSC_ROFS_CTL 3

// register offsets (byte addresses)
`define BSC_REG_CTRL 8'h00
`define BSC_REG_STATUS 8'h04
`define BSC_REG_SHIFT_LO 8'h08
`define BSC_REG_SHIFT_HI 8'h0C

// reset values
`define BSC_RST_CTRL 1'b0
`define BSC_RST_CTL_CELL 1'b1
`define BSC_RST_DATA_CELL 1'b0
`define BSC_RST_RDATA 32'h0000_0000

`endif

//--- hdl/bsc_pkg.sv
// Purpose: shared types of the boundary scan segment
// Assumes: bsc_defines.svh on the include path
// Notes: constants live in the header
`include "bsc_defines.svh"
package bsc_pkg;
    typedef logic [2:0] bsc_ir_type;
    typedef logic [`BSC_SEG_LEN-1:0] bsc_seg_type;
    typedef logic [`BSC_NUM_CHAN-1:0] bsc_chan_type;
    typedef logic [`BSC_NUM_IO-1:0] bsc_io_type;
endpackage

//--- hdl/bsc_cell.sv
// Purpose: one boundary scan cell, shift stage plus update stage
// Assumes: strobes are one hclk cycle per test clock step
// Notes: update stage holds what drives pins or enables
module bsc_cell #(
    parameter logic RESET_UPD = 1'b0
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic capture_en,
    input wire logic shift_en,
    input wire logic update_en,
    input wire logic capture_d,
    input wire logic scan_in,
    output logic scan_q,
    output logic update_q
);
    logic scan_d;
    logic update_d;

    assign scan_d = capture_en ? capture_d : (shift_en ? scan_in : scan_q);
    assign update_d = update_en ? scan_q : update_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scan_q <= 1'b0;
            update_q <= RESET_UPD;
        end else begin
            scan_q <= scan_d;
            update_q <= update_d;
        end
    end
endmodule

//--- hdl/bsc_segment.sv
// Purpose: boundary scan cells 16 to 56 with pin muxing and an AHB-Lite view
// Assumes: tap strobes and instruction come from the tap segment on hclk
// Notes: scan enters at cell 56 and leaves from cell 16
// How it works
// RULE1: direction cell zero drives all io pins
// RULE2: each io pin driven by own drive cell
// RULE3: direction cell one floats pins, capture levels; no cell here captures user_io_pins_i, the direction cell captures io_float_w
// RULE4: channel 1 control cell floats its outputs
// RULE5: channel 0 control cell floats its outputs
// RULE6: channel 3 control cell floats its outputs
// RULE7: channel 2 control cell floats its outputs
// RULE8: ack control zero drives ack cell value
// RULE9: ack control one floats the ack pin
// RULE10: chain loads only under extest or sample
// RULE11: extest captures pins, applies updated patterns
// RULE12: control cells act only after update
//
// Our own choices: the AHB-Lite slave port and the register offsets.
module bsc_segment (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire bsc_pkg::bsc_ir_type ir_code,
    input wire logic capture_dr,
    input wire logic shift_dr,
    input wire logic update_dr,
    input wire logic seg_scan_in,
    output logic seg_scan_out,
    input wire bsc_pkg::bsc_io_type io_drive_cell,
    input wire bsc_pkg::bsc_io_type user_io_pins_i,
    output bsc_pkg::bsc_io_type user_io_pins_o,
    output bsc_pkg::bsc_io_type user_io_pins_oe,
    input wire bsc_pkg::bsc_io_type core_io_out,
    input wire logic core_io_oe,
    input wire bsc_pkg::bsc_chan_type tx_clk_i,
    input wire bsc_pkg::bsc_chan_type tx_pos_i,
    input wire bsc_pkg::bsc_chan_type tx_neg_i,
    input wire bsc_pkg::bsc_chan_type core_rx_clk,
    input wire bsc_pkg::bsc_chan_type core_rx_pos,
    input wire bsc_pkg::bsc_chan_type core_rx_neg,
    input wire bsc_pkg::bsc_chan_type core_rx_oe,
    input wire bsc_pkg::bsc_chan_type core_loss_of_signal,
    output bsc_pkg::bsc_chan_type rx_clk_o,
    output bsc_pkg::bsc_chan_type rx_clk_oe,
    output bsc_pkg::bsc_chan_type rx_positive_data_o,
    output bsc_pkg::bsc_chan_type rx_positive_data_oe,
    output bsc_pkg::bsc_chan_type rx_negative_data_o,
    output bsc_pkg::bsc_chan_type rx_negative_data_oe,
    output bsc_pkg::bsc_chan_type loss_of_signal_o,
    input wire logic core_int_n,
    output logic int_n_o,
    input wire logic core_ack,
    input wire logic core_ack_oe,
    output logic ack_o,
    output logic ack_oe,
    input wire logic mode1_i,
    input wire logic host_wr_n_i,
    input wire logic host_rd_n_i,
    input wire logic host_ale_i,
    input wire logic host_cs_n_i
);
    // absolute position of a cell of a channel group
    function automatic int chan_pos(input int ch, input int ofs);
        int base;
        int pos;
        base = `BSC_CH0_BASE;
        pos = 0;
        if (ch == 1) begin
            base = `BSC_CH1_BASE;
        end else if (ch == 2) begin
            base = `BSC_CH2_BASE;
        end else if (ch == 3) begin
            base = `BSC_CH3_BASE;
        end
        // groups of channels 2 and 3 start at loss of signal, control cell sits mid group
        if (ch >= 2 && ofs == `BSC_OFS_CTL) begin
            pos = base + `BSC_ROFS_CTL;
        end else if (ch >= 2 && ofs == `BSC_OFS_RXP) begin
            pos = base + `BSC_ROFS_RXP;
        end else if (ch >= 2 && ofs == `BSC_OFS_RXN) begin
            pos = base + `BSC_ROFS_RXN;
        end else if (ch >= 2) begin
            pos = base + `BSC_GROUP_LAST - ofs;
        end else begin
            pos = base + ofs;
        end
        return pos;
    endfunction

    function automatic int loc(input int pos);
        return pos - `BSC_SEG_FIRST;
    endfunction

    function automatic logic is_ctl(input int idx);
        logic r;
        r = (idx == loc(`BSC_POS_IO_DIR)) || (idx == loc(`BSC_POS_ACK_CTL));
        for (int c = 0; c < `BSC_NUM_CHAN; c++) begin
            if (idx == loc(chan_pos(c, `BSC_OFS_CTL))) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    localparam int L_IO_DIR = loc(`BSC_POS_IO_DIR);
    localparam int L_ACK = loc(`BSC_POS_ACK);
    localparam int L_ACK_CTL = loc(`BSC_POS_ACK_CTL);
    localparam int L_INT = loc(`BSC_POS_INT);

    wire extest_w;
    wire scan_sel_w;
    wire cap_en_w;
    wire shift_en_w;
    wire upd_en_w;
    wire [`BSC_SEG_LEN-1:0] cap_w;
    wire [`BSC_SEG_LEN-1:0] chain_in_w;
    bsc_pkg::bsc_seg_type scan_w;
    bsc_pkg::bsc_seg_type upd_w;
    wire io_float_w;
    wire ack_float_w;
    bsc_pkg::bsc_chan_type rx_float_w;
    logic mission_float_q;
    logic mission_float_d;

    assign extest_w = (ir_code == `BSC_IR_EXTEST);
    assign scan_sel_w = extest_w || (ir_code == `BSC_IR_SAMPLE); // RULE10
    assign cap_en_w = scan_sel_w && capture_dr; // RULE11
    assign shift_en_w = scan_sel_w && shift_dr; // RULE10
    assign upd_en_w = scan_sel_w && update_dr; // RULE12
    assign chain_in_w = {seg_scan_in, scan_w[`BSC_SEG_LEN-1:1]};
    assign seg_scan_out = scan_w[0];

    genvar gi;
    generate
        for (gi = 0; gi < `BSC_SEG_LEN; gi++) begin : g_cell
            bsc_cell #(
                .RESET_UPD(is_ctl(gi) ? `BSC_RST_CTL_CELL : `BSC_RST_DATA_CELL)
            ) u_cell (
                .hclk(hclk),
                .hresetn(hresetn),
                .capture_en(cap_en_w),
                .shift_en(shift_en_w),
                .update_en(upd_en_w),
                .capture_d(cap_w[gi]),
                .scan_in(chain_in_w[gi]),
                .scan_q(scan_w[gi]),
                .update_q(upd_w[gi])
            );
        end
    endgenerate

    // user io pins
    assign io_float_w = extest_w ? upd_w[L_IO_DIR] : (!core_io_oe || mission_float_q); // RULE12
    assign user_io_pins_oe = {`BSC_NUM_IO{!io_float_w}}; // RULE1 RULE3
    assign user_io_pins_o = extest_w ? io_drive_cell : core_io_out; // RULE2
    assign cap_w[L_IO_DIR] = io_float_w;

    // receive channels
    genvar gc;
    generate
        for (gc = 0; gc < `BSC_NUM_CHAN; gc++) begin : g_chan
            localparam int P_TCLK = loc(chan_pos(gc, `BSC_OFS_TCLK));
            localparam int P_TDP = loc(chan_pos(gc, `BSC_OFS_TDP));
            localparam int P_TDN = loc(chan_pos(gc, `BSC_OFS_TDN));
            localparam int P_RCLK = loc(chan_pos(gc, `BSC_OFS_RCLK));
            localparam int P_RXP = loc(chan_pos(gc, `BSC_OFS_RXP));
            localparam int P_RXN = loc(chan_pos(gc, `BSC_OFS_RXN));
            localparam int P_CTL = loc(chan_pos(gc, `BSC_OFS_CTL));
            localparam int P_LOS = loc(chan_pos(gc, `BSC_OFS_LOS));
            // one control cell floats clock and both data pins
            assign rx_float_w[gc] = extest_w ? upd_w[P_CTL]
                                             : (!core_rx_oe[gc] || mission_float_q); // RULE4 RULE5 RULE6 RULE7
            assign rx_clk_oe[gc] = !rx_float_w[gc]; // RULE4 RULE5 RULE6 RULE7
            assign rx_positive_data_oe[gc] = !rx_float_w[gc]; // RULE4 RULE5 RULE6 RULE7
            assign rx_negative_data_oe[gc] = !rx_float_w[gc]; // RULE4 RULE5 RULE6 RULE7
            assign rx_clk_o[gc] = extest_w ? upd_w[P_RCLK] : core_rx_clk[gc]; // RULE11
            assign rx_positive_data_o[gc] = extest_w ? upd_w[P_RXP] : core_rx_pos[gc]; // RULE11
            assign rx_negative_data_o[gc] = extest_w ? upd_w[P_RXN] : core_rx_neg[gc]; // RULE11
            assign loss_of_signal_o[gc] = extest_w ? upd_w[P_LOS] : core_loss_of_signal[gc]; // RULE11
            assign cap_w[P_TCLK] = tx_clk_i[gc];
            assign cap_w[P_TDP] = tx_pos_i[gc];
            assign cap_w[P_TDN] = tx_neg_i[gc];
            assign cap_w[P_RCLK] = rx_clk_o[gc];
            assign cap_w[P_RXP] = rx_positive_data_o[gc];
            assign cap_w[P_RXN] = rx_negative_data_o[gc];
            assign cap_w[P_CTL] = rx_float_w[gc];
            assign cap_w[P_LOS] = loss_of_signal_o[gc];
        end
    endgenerate

    // host interface pins
    assign ack_float_w = extest_w ? upd_w[L_ACK_CTL] : (!core_ack_oe || mission_float_q); // RULE9 RULE12
    assign ack_oe = !ack_float_w; // RULE8 RULE9
    assign ack_o = extest_w ? upd_w[L_ACK] : core_ack; // RULE8
    assign int_n_o = extest_w ? upd_w[L_INT] : core_int_n; // RULE11
    assign cap_w[L_INT] = int_n_o;
    assign cap_w[L_ACK] = ack_o;
    assign cap_w[L_ACK_CTL] = ack_float_w;
    assign cap_w[loc(`BSC_POS_MODE1)] = mode1_i;
    assign cap_w[loc(`BSC_POS_WR)] = host_wr_n_i;
    assign cap_w[loc(`BSC_POS_RD)] = host_rd_n_i;
    assign cap_w[loc(`BSC_POS_ALE)] = host_ale_i;
    assign cap_w[loc(`BSC_POS_CS)] = host_cs_n_i;

    // ahb-lite slave, zero wait states
    logic [7:0] addr_q;
    logic [7:0] addr_d;
    logic wr_q;
    logic wr_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    wire take_w;
    wire [31:0] status_w;
    wire [31:0] sel_rdata_w;
    wire [7:0] a_w;

    assign take_w = hsel && hready && htrans[1];
    assign a_w = haddr[7:0];
    assign addr_d = take_w ? a_w : addr_q;
    assign wr_d = take_w && hwrite;
    assign status_w = {23'h00_0000, scan_sel_w, extest_w,
                       upd_w[L_ACK_CTL], rx_float_w, io_float_w, mission_float_q};
    assign sel_rdata_w = (a_w == `BSC_REG_CTRL) ? {31'h0000_0000, mission_float_q} :
                         (a_w == `BSC_REG_STATUS) ? status_w :
                         (a_w == `BSC_REG_SHIFT_LO) ? scan_w[31:0] :
                         (a_w == `BSC_REG_SHIFT_HI) ? {23'h00_0000, scan_w[`BSC_SEG_LEN-1:32]} :
                         `BSC_RST_RDATA;
    assign rdata_d = (take_w && !hwrite) ? sel_rdata_w : rdata_q;
    assign mission_float_d = (wr_q && (addr_q == `BSC_REG_CTRL)) ? hwdata[0] : mission_float_q;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rdata_q <= `BSC_RST_RDATA;
            mission_float_q <= `BSC_RST_CTRL;
        end else begin
            addr_q <= addr_d;
            wr_q <= wr_d;
            rdata_q <= rdata_d;
            mission_float_q <= mission_float_d;
        end
    end
endmodule

//--- dv/bsc_segment_asserts.sv
// Purpose: pin checks on the scan segment
// Assumes: one domain, hclk
// Notes: bound onto bsc_segment
module bsc_segment_asserts (
    input wire logic hclk,
    input wire logic hresetn,
    input wire bsc_pkg::bsc_ir_type ir_code,
    input wire logic update_dr,
    input wire logic seg_scan_out,
    input wire bsc_pkg::bsc_io_type io_drive_cell,
    input wire bsc_pkg::bsc_io_type core_io_out,
    input wire bsc_pkg::bsc_io_type user_io_pins_o,
    input wire bsc_pkg::bsc_io_type user_io_pins_oe,
    input wire bsc_pkg::bsc_chan_type rx_clk_oe,
    input wire bsc_pkg::bsc_chan_type rx_positive_data_oe,
    input wire bsc_pkg::bsc_chan_type rx_negative_data_oe,
    input wire logic ack_o,
    input wire logic ack_oe
);
    wire ext = (ir_code == 3'h0);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_no_update;
        ext && !update_dr ##1 ext;
    endsequence
    sequence s_frozen_ir;
        ir_code != 3'h0 && ir_code != 3'h4 ##1 1'b1;
    endsequence
    chk_io_oe_all: assert property (ext |-> user_io_pins_oe == 8'h00 || user_io_pins_oe == 8'hff)
        else $error("io enables differ");
    chk_io_drive_src: assert property (ext && user_io_pins_oe[0] |-> user_io_pins_o == io_drive_cell)
        else $error("io level not from drive cells");
    chk_io_oe_hold: assert property (s_no_update |-> $stable(user_io_pins_oe))
        else $error("io enable moved without update");
    chk_rx_oe_group: assert property (ext |-> rx_clk_oe == rx_positive_data_oe &&
        rx_clk_oe == rx_negative_data_oe) else $error("rx enables split");
    chk_rx_oe_hold: assert property (s_no_update |->
        $stable({rx_clk_oe, rx_positive_data_oe, rx_negative_data_oe})) else $error("rx enable moved");
    chk_ack_hold: assert property (s_no_update |-> $stable({ack_oe, ack_o}))
        else $error("ack pin moved without update");
    chk_mission_io: assert property (!ext && user_io_pins_oe[0] |-> user_io_pins_o == core_io_out)
        else $error("mission io path broken");
    chk_scan_frozen: assert property (s_frozen_ir |-> $stable(seg_scan_out))
        else $error("chain moved under other code");
endmodule

bind bsc_segment bsc_segment_asserts chk_u (.hclk, .hresetn, .ir_code, .update_dr, .seg_scan_out, .io_drive_cell,
    .core_io_out, .user_io_pins_o, .user_io_pins_oe, .rx_clk_oe, .rx_positive_data_oe, .rx_negative_data_oe,
    .ack_o, .ack_oe);

//--- dv/bsc_scan_tester.sv
// Purpose: tap-side tester stepping capture, shift, update
// Assumes: strobes change after a rising edge
// Notes: idle serial input toggles so stale data never looks valid
module bsc_scan_tester (
    input wire logic hclk,
    output bsc_pkg::bsc_ir_type ir_code,
    output logic capture_dr,
    output logic shift_dr,
    output logic update_dr,
    output logic seg_scan_in,
    input wire logic seg_scan_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        ir_code = 3'h7;
        {capture_dr, shift_dr, update_dr, seg_scan_in} = 4'h0;
    end
    always @(posedge hclk) begin
        if (!shift_dr && !capture_dr) begin
            seg_scan_in <= ~seg_scan_in;
        end
    end
    task automatic set_ir(input bsc_pkg::bsc_ir_type code);
        @(posedge hclk);
        ir_code <= code;
        @(posedge hclk);
    endtask
    // gap cycles pause before update, a slow tester
    task automatic scan(input bsc_pkg::bsc_seg_type din, input int gap, output bsc_pkg::bsc_seg_type dout);
        @(posedge hclk);
        capture_dr <= 1'b1;
        for (int k = 0; k < $bits(din); k++) begin
            @(posedge hclk);
            capture_dr <= 1'b0;
            shift_dr <= 1'b1;
            seg_scan_in <= din[k];
            @(negedge hclk);
            dout[k] = seg_scan_out;
        end
        @(posedge hclk);
        shift_dr <= 1'b0;
        repeat (gap) @(posedge hclk);
        update_dr <= 1'b1;
        @(posedge hclk);
        update_dr <= 1'b0;
        @(posedge hclk);
    endtask
endmodule

//--- dv/tb_boundary_scan_cell_chain.sv
// Purpose: self-checking bench for the middle scan segment
// Assumes: tester model drives tap strobes, bench drives AHB and pins
// Notes: reads checked by a monitor against a queue
module tb_boundary_scan_cell_chain;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic rd_ph = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] hrdata;
    logic [31:0] exp_q[$];
    logic hreadyout, hresp, capture_dr, shift_dr, update_dr, seg_scan_in, seg_scan_out;
    logic core_int_n, int_n_o, core_ack, core_ack_oe, ack_o, ack_oe;
    logic hready;
    logic [2:0] hsize = 3'h2;
    logic core_io_oe;
    assign hready = hreadyout;
    logic mode1_i, host_wr_n_i, host_rd_n_i, host_ale_i, host_cs_n_i;
    bsc_pkg::bsc_ir_type ir_code;
    bsc_pkg::bsc_io_type io_drive_cell, user_io_pins_i, user_io_pins_o, user_io_pins_oe, core_io_out;
    bsc_pkg::bsc_chan_type tx_clk_i, tx_pos_i, tx_neg_i, core_rx_clk, core_rx_pos, core_rx_neg, core_rx_oe;
    bsc_pkg::bsc_chan_type core_loss_of_signal, rx_clk_o, rx_clk_oe, rx_positive_data_o, rx_positive_data_oe;
    bsc_pkg::bsc_chan_type rx_negative_data_o, rx_negative_data_oe, loss_of_signal_o;
    wire [16:0] rx_pins_w = {rx_clk_o, rx_positive_data_o, rx_negative_data_o, loss_of_signal_o, int_n_o};
    bsc_pkg::bsc_seg_type pat, dout;
    integer seed = 32'h0a32_1e88;
    int num_errors = 0;
    int checked = 0;
    bsc_segment dut_u (.*);
    bsc_scan_tester tester_u (.*);
    always #50 hclk = ~hclk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (e !== g) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic test_done;
        if (num_errors == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // for reads d is the expected word
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'h2;
        haddr <= {24'h00_0000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        if (!wr) exp_q.push_back(d);
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    always @(posedge hclk) rd_ph <= hsel && htrans[1] && !hwrite;
    always @(negedge hclk) begin
        if (rd_ph) begin
            chk("hrdata", exp_q.pop_front(), hrdata);
            chk("hresp", 32'h0000_0000, hresp);
        end
    end
    initial begin
        #2_000_000;
        num_errors++;
        test_done();
    end
    initial begin
        @(posedge hclk);
        {core_io_out, io_drive_cell, user_io_pins_i, tx_clk_i, tx_pos_i, tx_neg_i, core_rx_clk, core_rx_pos,
            core_rx_neg, core_rx_oe, core_loss_of_signal, core_int_n, core_ack, core_ack_oe, mode1_i, host_wr_n_i,
            host_rd_n_i, host_ale_i, host_cs_n_i, core_io_oe} <= {$random(seed), $random(seed)};
        repeat (15) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        ahb(1'b0, 8'h00, 32'h0000_0000);
        ahb(1'b1, 8'h00, 32'h0000_0001);
        ahb(1'b0, 8'h00, 32'h0000_0001);
        ahb(1'b0, 8'h10, 32'h0000_0000);
        chk("forced oe", 8'h00, user_io_pins_oe);
        ahb(1'b1, 8'h00, 32'h0000_0000);
        tester_u.set_ir(3'h4);
        chk("mission out", core_io_out, user_io_pins_o);
        chk("mission oe", {8{core_io_oe}}, user_io_pins_oe);
        tester_u.set_ir(3'h0);
        // ch0 and ch2 float, ack driven high, rx positive of ch1 and ch3 high, int high
        pat = 41'h0c_2010_8020;
        tester_u.scan(pat, 0, dout);
        chk("captured inputs", {tx_clk_i[1], mode1_i, host_cs_n_i}, {dout[1], dout[17], dout[40]});
        chk("io oe", 8'hff, user_io_pins_oe);
        chk("io out", io_drive_cell, user_io_pins_o);
        chk("rx oe", {3{4'b1010}}, {rx_clk_oe, rx_positive_data_oe, rx_negative_data_oe});
        chk("ack", 2'b11, {ack_oe, ack_o});
        chk("rx pins", {4'h0, 4'ha, 4'h0, 4'h0, 1'b1}, rx_pins_w);
        ahb(1'b0, 8'h04, 32'h0000_0194);
        ahb(1'b0, 8'h08, pat[31:0]);
        tester_u.scan(~pat, 3, dout);
        chk("ctl captures", 7'b0010101, {dout[0], dout[7], dout[15], dout[21], dout[29], dout[36], dout[35]});
        chk("io oe", 8'h00, user_io_pins_oe);
        chk("rx oe", {3{4'b0101}}, {rx_clk_oe, rx_positive_data_oe, rx_negative_data_oe});
        chk("ack oe", 1'b0, ack_oe);
        chk("rx pins", {4'hf, 4'h5, 4'hf, 4'hf, 1'b0}, rx_pins_w);
        ahb(1'b0, 8'h0c, {23'h00_0000, ~pat[40:32]});
        tester_u.set_ir(3'h7);
        tester_u.scan(pat, 0, dout);
        tester_u.set_ir(3'h0);
        chk("frozen oe", 8'h00, user_io_pins_oe);
        ahb(1'b0, 8'h0c, {23'h00_0000, ~pat[40:32]});
        test_done();
    end
endmodule
